// ==== logic/tce_pkg.sv ====
////////////////////////////////////////////////////////////
// Shared constants for the event window counter
package tce_pkg;
   // Register byte offsets on the bus
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CMP_LO = 8'h04;
   localparam logic [7:0] OFS_CMP_HI = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0C;
   // Control field positions
   localparam int CTL_MODE = 0;
   localparam int CTL_SRC_LO = 2;
   localparam int CTL_RUN = 5;
   // Reset values
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [15:0] CMP_RST = 16'hFFFF;
   localparam logic [7:0] BYTE_RST = 8'h00;
   // Operating mode codes
   localparam logic MODE_TIMER = 1'b0;
   localparam logic MODE_WINDOW = 1'b1;
   // Source select codes
   localparam logic [2:0] SRC_SLOWEST = 3'h0;
   localparam logic [2:0] SRC_SLOW = 3'h1;
   localparam logic [2:0] SRC_MID = 3'h2;
   localparam logic [2:0] SRC_FAST = 3'h3;
   localparam logic [2:0] SRC_HF = 3'h4;
   localparam logic [2:0] SRC_LF = 3'h5;
   localparam logic [2:0] SRC_RSVD = 3'h6;
   localparam logic [2:0] SRC_PIN = 3'h7;
   // Tick strobe indexes from the divider chain
   localparam int TK_FC23 = 0;
   localparam int TK_FC13 = 1;
   localparam int TK_FC8 = 2;
   localparam int TK_FC3 = 3;
   localparam int TK_FC = 4;
   localparam int TK_FS = 5;
   localparam int TK_FS15 = 6;
   localparam int TK_FS5 = 7;
   localparam int TK_N = 8;
   // Compare bits kept in the high-clock warm-up case
   localparam int HF_MASK_LSB = 11;
endpackage : tce_pkg

// ==== logic/tce_counter.sv ====
// The implementer's own choices: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
module tce_counter
   import tce_pkg::*;
#(
   parameter int CNT_W = 16
) (
   // Clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // APB slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Divider ticks and power state
   input wire logic [TK_N-1:0] src_tick,
   input wire logic divider_low_clock_select,
   input wire logic pm_slow,
   input wire logic pm_slow_mode_two,
   input wire logic stop_entry,
   // External pin
   input wire logic count_input_pin,
   // Event out
   output logic match_interrupt
);

   ////////////////////////////////////////////////////////////
   // State
   logic run_bit_q; // Counter running
   logic op_mode_q; // Timer or window
   logic [2:0] src_q; // Source select
   logic [CNT_W-1:0] cnt_q; // Up counter
   logic [CNT_W-1:0] cnt_d; // Counter next
   logic [15:0] cmp_q; // Active compare
   logic [7:0] lo_q; // Low byte held
   logic pend_q; // Low byte written
   logic pin_s1_q; // Sync stage one
   logic pin_s2_q; // Sync stage two
   logic pin_s3_q; // Edge history
   logic irq_q; // Interrupt pulse
   logic [31:0] prdata_q; // Read data
   logic pready_q; // Access answer
   logic pslverr_q; // Unmapped answer

   ////////////////////////////////////////////////////////////
   // Bus decode
   wire acc_w = psel & penable; // Access phase
   wire fin_w = acc_w & pready_q; // Completing edge
   wire wr_w = fin_w & pwrite; // Write takes effect
   wire hit_ctrl = (paddr == OFS_CTRL);
   wire hit_lo = (paddr == OFS_CMP_LO);
   wire hit_hi = (paddr == OFS_CMP_HI);
   wire hit_stat = (paddr == OFS_STATUS);
   wire mapped_w = hit_ctrl | hit_lo | hit_hi | hit_stat;
   wire wr_ctrl = wr_w & hit_ctrl;
   wire wr_lo = wr_w & hit_lo;
   wire wr_hi = wr_w & hit_hi;

   ////////////////////////////////////////////////////////////
   // Source decode
   // source clock choice
   function automatic logic pick_tick(
      input logic [2:0] s,
      input logic [TK_N-1:0] t,
      input logic dv,
      input logic slow,
      input logic slow_mode_two,
      input logic win
   );
      logic r;
      r = 1'b0;
      if (!slow) begin
         // Normal or idle
         case (s)
            SRC_SLOWEST: r = dv ? t[TK_FS15] : t[TK_FC23];
            SRC_SLOW: r = dv ? t[TK_FS5] : t[TK_FC13];
            SRC_MID: r = t[TK_FC8];
            SRC_FAST: r = t[TK_FC3];
            SRC_LF: r = t[TK_FS];
            default: r = 1'b0;
         endcase
      end else if (!win) begin
         case (s)
            SRC_SLOWEST: r = t[TK_FS15];
            SRC_SLOW: r = t[TK_FS5];
            SRC_HF: r = slow_mode_two & t[TK_FC];
            default: r = 1'b0;
         endcase
      end
      return r;
   endfunction : pick_tick

   wire win_w = (op_mode_q == MODE_WINDOW);
   wire ext_w = ~win_w & (src_q == SRC_PIN);
   wire tick_w = pick_tick(src_q, src_tick, divider_low_clock_select,
                           pm_slow, pm_slow_mode_two, win_w);
   wire hf_warm_w = ~win_w & pm_slow & pm_slow_mode_two & (src_q == SRC_HF);

   ////////////////////////////////////////////////////////////
   // Pin edges
   wire pin_rise = pin_s2_q & ~pin_s3_q;
   wire pin_fall = ~pin_s2_q & pin_s3_q;

   ////////////////////////////////////////////////////////////
   // Match and advance
   // upper five bits
   wire eq_full = (cnt_q == cmp_q);
   wire eq_high = (cnt_q[15:HF_MASK_LSB] == cmp_q[15:HF_MASK_LSB]);
   wire eq_w = hf_warm_w ? eq_high : eq_full;
   wire match_w = run_bit_q & eq_w & (~ext_w | pin_fall);
   wire ev_adv = ext_w & pin_rise;
   wire win_adv = win_w & tick_w & pin_s2_q;
   wire tm_adv = ~win_w & ~ext_w & tick_w;
   wire adv_w = run_bit_q & (ev_adv | win_adv | tm_adv);

   ////////////////////////////////////////////////////////////
   // Counter next value
   always_comb begin
      cnt_d = cnt_q;
      if (!run_bit_q) begin
         cnt_d = '0;
      end else if (match_w) begin
         // clear on match
         // A tick in the match cycle is dropped
         cnt_d = '0;
      end else if (adv_w) begin
         cnt_d = cnt_q + CNT_W'(1);
      end
   end

   ////////////////////////////////////////////////////////////
   // Counter and interrupt
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_q <= '0;
         irq_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         irq_q <= match_w;
      end
   end

   ////////////////////////////////////////////////////////////
   // Pin synchroniser
   // Reset low matches the idle pin, no false edge
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_s1_q <= 1'b0;
         pin_s2_q <= 1'b0;
         pin_s3_q <= 1'b0;
      end else begin
         pin_s1_q <= count_input_pin;
         pin_s2_q <= pin_s1_q;
         pin_s3_q <= pin_s2_q;
      end
   end

   ////////////////////////////////////////////////////////////
   // Control register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         run_bit_q <= CTRL_RST[CTL_RUN];
         op_mode_q <= CTRL_RST[CTL_MODE];
         src_q <= CTRL_RST[CTL_SRC_LO +: 3];
      end else begin
         // stop entry halts
         // Stop entry wins over a same-cycle start
         if (stop_entry) begin
            run_bit_q <= 1'b0;
         end else if (wr_ctrl) begin
            run_bit_q <= pwdata[CTL_RUN];
         end
         // Mode and source latch
         if (wr_ctrl) begin
            op_mode_q <= pwdata[CTL_MODE];
            src_q <= pwdata[CTL_SRC_LO +: 3];
         end
      end
   end

   ////////////////////////////////////////////////////////////
   // Compare pair load
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cmp_q <= CMP_RST;
         lo_q <= BYTE_RST;
         pend_q <= 1'b0;
      end else begin
         if (wr_lo) begin
            lo_q <= pwdata[7:0];
            pend_q <= 1'b1;
         end else if (wr_hi) begin
            pend_q <= 1'b0;
            if (pend_q) begin
               cmp_q <= {pwdata[7:0], lo_q};
            end else if (hf_warm_w) begin
               cmp_q <= {pwdata[7:0], cmp_q[7:0]};
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////
   // Read mux
   // unstable bits read zero
   wire [7:0] ctrl_rd = {2'b00, run_bit_q, src_q, 1'b0, op_mode_q};
   wire [31:0] stat_rd = {15'h0000, run_bit_q, 16'(cnt_q)};
   wire [31:0] rd_w = hit_ctrl ? {24'h000000, ctrl_rd} :
                      hit_lo ? {24'h000000, cmp_q[7:0]} :
                      hit_hi ? {24'h000000, cmp_q[15:8]} :
                      hit_stat ? stat_rd : 32'h00000000;

   ////////////////////////////////////////////////////////////
   // APB answer, one wait state
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h00000000;
      end else begin
         pready_q <= acc_w & ~pready_q;
         pslverr_q <= acc_w & ~pready_q & ~mapped_w;
         // Data only on reads
         if (acc_w & ~pready_q & ~pwrite) begin
            prdata_q <= rd_w;
         end else begin
            prdata_q <= 32'h00000000;
         end
      end
   end

   ////////////////////////////////////////////////////////////
   // Outputs
   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign match_interrupt = irq_q;

   ////////////////////////////////////////////////////////////
   // Checks
   // Named steps of a compare load
   sequence seq_lo_write;
      wr_lo;
   endsequence
   sequence seq_hi_write;
      pend_q && wr_hi;
   endsequence

   AST_STOP_CLEARS: assert property (@(posedge pclk) disable iff (!presetn)
      stop_entry |=> !run_bit_q)
      else $error("stop entry left counter running");

   AST_STOPPED_ZERO: assert property (@(posedge pclk) disable iff (!presetn)
      !run_bit_q |=> cnt_q == '0)
      else $error("stopped counter not zero");

   AST_COMPARE_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
      seq_lo_write ##1 (!wr_hi)[*2] |-> $stable(cmp_q) && pend_q)
      else $error("compare changed before high byte");

   AST_PAIR_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
      seq_hi_write |=> cmp_q == {$past(pwdata[7:0]), $past(lo_q)})
      else $error("compare pair not loaded");

   AST_MATCH_IRQ: assert property (@(posedge pclk) disable iff (!presetn)
      run_bit_q && !ext_w && eq_full && !hf_warm_w |=> match_interrupt && cnt_q == '0)
      else $error("timer match missed");

   AST_EVENT_RISE: assert property (@(posedge pclk) disable iff (!presetn)
      run_bit_q && ext_w && pin_rise && !match_w && !stop_entry && !wr_ctrl
      |=> cnt_q == $past(cnt_q) + CNT_W'(1))
      else $error("event edge not counted");

   AST_EVENT_FALL: assert property (@(posedge pclk) disable iff (!presetn)
      match_interrupt && $past(ext_w) |-> $past(pin_fall))
      else $error("event match off falling edge");

   AST_WINDOW_LOW: assert property (@(posedge pclk) disable iff (!presetn)
      run_bit_q && win_w && !pin_s2_q && !match_w && !stop_entry && !wr_ctrl
      |=> $stable(cnt_q))
      else $error("window counted with pin low");

   AST_NO_ADVANCE: assert property (@(posedge pclk) disable iff (!presetn)
      run_bit_q && !ext_w && src_q == SRC_RSVD && !match_w && !wr_ctrl && !stop_entry
      |=> $stable(cnt_q))
      else $error("reserved source advanced counter");

   AST_CTRL_READ: assert property (@(posedge pclk) disable iff (!presetn)
      acc_w && !pready_q && !pwrite && hit_ctrl |=> pready && prdata[7:6] == 2'b00 && !prdata[1])
      else $error("control read bits not zero");

endmodule : tce_counter

// ==== tb/tce_pin_src.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// External pulse source driving the count pin
module tce_pin_src #(
   parameter int HALF = 4
) (
   // Clock
   input wire logic pclk,
   // Commands from the bench
   input wire logic hold,
   input wire logic go,
   input wire logic [7:0] n,
   // Pin
   output logic pin
);
   int left = 0; // Edges still to make
   int ph = 0; // Cycles in current level
   logic tog = 1'b0; // Pulse train level
   // Held level or pulse train, low when idle
   assign pin = hold | tog;
   always @(posedge pclk) begin
      if (go) begin
         left <= 2 * n;
         ph <= 0;
      end else if (left > 0) begin
         ph <= (ph == HALF - 1) ? 0 : ph + 1;
         if (ph == HALF - 1) begin
            tog <= ~tog;
            left <= left - 1;
         end
      end
   end
endmodule : tce_pin_src

// ==== tb/timer16_event_window_counter_tb.sv ====
`timescale 1ns/1ps
////////////////////////////////////////////////////////////
// Bench for the event window counter
module timer16_event_window_counter_tb;
   import tce_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic pready, pslverr, match_interrupt, count_input_pin;
   logic [7:0] src_tick = '0, pn = '0;
   logic dvs = 0, pm_slow = 0, pm_s2 = 0, stop_entry = 0, hold = 0, go = 0;
   int errors = 0, tests_run = 0, irq_n = 0, b, n, seed = 32'hedff29fd;
   logic [32:0] q[$]; // Expected {pslverr, prdata}
   int tki[6] = '{TK_FC23, TK_FC13, TK_FC8, TK_FC3, TK_FC, TK_FS};
   // Clock
   always #5 pclk = ~pclk;
   tce_counter dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .src_tick(src_tick), .divider_low_clock_select(dvs), .pm_slow(pm_slow), .pm_slow_mode_two(pm_s2),
      .stop_entry(stop_entry), .count_input_pin(count_input_pin), .match_interrupt(match_interrupt));
   tce_pin_src src (.pclk(pclk), .hold(hold), .go(go), .n(pn), .pin(count_input_pin));
   // Compare and count
   task chk(input logic [32:0] s, input logic [32:0] e);
      tests_run++;
      if (s !== e) begin
         errors++;
         $display("BAD %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task give_verdict;
      if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : give_verdict
   // APB transfer, expectation noted first
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [32:0] e);
      int k;
      q.push_back(e);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge pclk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      if (k >= 50) chk(33'h0, 33'h1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   // Stop, then start with mode and source
   // mode set while stopped
   task cfg(input logic m, input logic [2:0] s);
      apb(1, OFS_CTRL, {26'h0, 1'b0, s, 1'b0, m}, '0);
      apb(1, OFS_CTRL, {26'h0, 1'b1, s, 1'b0, m}, '0);
   endtask : cfg
   // Tick strobes with random gaps
   task tk(input logic [7:0] m, input int c);
      repeat (c) begin
         @(posedge pclk);
         src_tick <= m;
         @(posedge pclk);
         src_tick <= '0;
         repeat ($random(seed) & 3) @(posedge pclk);
      end
   endtask : tk
   task cmp(input logic [15:0] v);
      apb(1, OFS_CMP_LO, {24'h0, v[7:0]}, '0);
      apb(1, OFS_CMP_HI, {24'h0, v[15:8]}, '0);
   endtask : cmp
   // Result watcher
   always @(posedge pclk) begin
      if (match_interrupt === 1'b1) irq_n <= irq_n + 1;
      if (psel && penable && pready === 1'b1) chk({pslverr, prdata}, q.pop_front());
   end
   // Watchdog
   initial begin
      #300000;
      errors++;
      give_verdict;
   end
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      apb(0, OFS_CTRL, 0, '0);
      apb(0, 8'h10, 0, {1'b1, 32'h0});
      cmp(16'h0003);
      cfg(MODE_TIMER, SRC_FAST);
      b = irq_n;
      n = 6 + ($random(seed) & 3);
      tk(8'(1 << TK_FC3), n);
      apb(0, OFS_STATUS, 0, {16'h1, 16'(n % 3)});
      chk(33'(irq_n - b), 33'(n / 3));
      apb(1, OFS_CMP_LO, 5, '0);
      cfg(MODE_TIMER, SRC_FAST);
      b = irq_n;
      tk(8'(1 << TK_FC3), 3);
      repeat (3) @(posedge pclk);
      chk(33'(irq_n - b), 33'h1);
      apb(1, OFS_CMP_HI, 0, '0);
      cfg(MODE_TIMER, SRC_FAST);
      tk(8'(1 << TK_FC3), 4);
      apb(0, OFS_STATUS, 0, {16'h1, 16'h4});
      for (int c = 0; c < 6; c++) begin
         if (c == 4) continue;
         cfg(MODE_TIMER, 3'(c));
         tk(8'(1 << tki[c]), 2);
         apb(0, OFS_STATUS, 0, {16'h1, 16'h2});
      end
      dvs <= 1'b1;
      cfg(MODE_TIMER, SRC_SLOW);
      tk(8'(1 << TK_FS5), 2);
      apb(0, OFS_STATUS, 0, {16'h1, 16'h2});
      dvs <= 1'b0;
      cfg(MODE_TIMER, SRC_RSVD);
      tk(8'hFF, 3);
      apb(0, OFS_STATUS, 0, {16'h1, 16'h0});
      pm_slow <= 1'b1;
      cfg(MODE_TIMER, SRC_FAST);
      tk(8'hFF, 3);
      apb(0, OFS_STATUS, 0, {16'h1, 16'h0});
      cfg(MODE_TIMER, SRC_SLOWEST);
      tk(8'(1 << TK_FS15), 2);
      apb(0, OFS_STATUS, 0, {16'h1, 16'h2});
      cfg(MODE_TIMER, SRC_SLOW);
      tk(8'(1 << TK_FS5), 2);
      apb(0, OFS_STATUS, 0, {16'h1, 16'h2});
      // high clock in slow two, high byte only
      pm_s2 <= 1'b1;
      apb(1, OFS_CTRL, {26'h0, 1'b0, SRC_HF, 1'b0, MODE_TIMER}, '0);
      apb(1, OFS_CMP_HI, 32'h10, '0);
      apb(1, OFS_CTRL, {26'h0, 1'b1, SRC_HF, 1'b0, MODE_TIMER}, '0);
      b = irq_n;
      src_tick <= 8'(1 << TK_FC);
      repeat (4200) @(posedge pclk);
      src_tick <= '0;
      apb(0, OFS_STATUS, 0, {16'h1, 16'h0067});
      chk(33'(irq_n - b), 33'h1);
      pm_s2 <= 1'b0;
      cmp(16'h0005);
      pm_slow <= 1'b0;
      cfg(MODE_TIMER, SRC_PIN);
      b = irq_n;
      pn <= 8'h5; go <= 1'b1;
      @(posedge pclk) go <= 1'b0;
      repeat (60) @(posedge pclk);
      chk(33'(irq_n - b), 33'h1);
      apb(0, OFS_STATUS, 0, {16'h1, 16'h0});
      // window pin far slower than ticks
      cfg(MODE_WINDOW, SRC_FAST);
      hold <= 1'b1;
      repeat (5) @(posedge pclk);
      tk(8'(1 << TK_FC3), 3);
      hold <= 1'b0;
      repeat (5) @(posedge pclk);
      tk(8'(1 << TK_FC3), 3);
      apb(0, OFS_STATUS, 0, {16'h1, 16'h3});
      @(posedge pclk) stop_entry <= 1'b1;
      @(posedge pclk) stop_entry <= 1'b0;
      apb(0, OFS_CTRL, 0, {27'h0, SRC_FAST, 2'b01});
      apb(0, OFS_STATUS, 0, '0);
      give_verdict;
   end
endmodule : timer16_event_window_counter_tb
